// ==== sss_params.svh ====
`ifndef SSS_PARAMS_SVH
`define SSS_PARAMS_SVH

// ----------------------------------------------------------------------------
// clock and time base
// ----------------------------------------------------------------------------
`define SSS_CLK_MHZ          50
`define SSS_STEP_US          100
`define SSS_TICK_CYCLES      (`SSS_STEP_US * `SSS_CLK_MHZ)

// ----------------------------------------------------------------------------
// sequence times, in milliseconds or microseconds, and their tick counts
// ----------------------------------------------------------------------------
`define SSS_SCAN_MS          5
`define SSS_SCAN_TICKS       (`SSS_SCAN_MS * 1000 / `SSS_STEP_US)
`define SSS_MIN_DELAY_US     2000
`define SSS_MIN_DELAY_TICKS  (`SSS_MIN_DELAY_US / `SSS_STEP_US)
`define SSS_T2_MS            2
`define SSS_T5_MS            5
`define SSS_T10_MS           10
`define SSS_T20_MS           20
`define SSS_T2_TICKS         (`SSS_T2_MS * 1000 / `SSS_STEP_US)
`define SSS_T5_TICKS         (`SSS_T5_MS * 1000 / `SSS_STEP_US)
`define SSS_T10_TICKS        (`SSS_T10_MS * 1000 / `SSS_STEP_US)
`define SSS_T20_TICKS        (`SSS_T20_MS * 1000 / `SSS_STEP_US)

// ----------------------------------------------------------------------------
// strap levels and set-point
// ----------------------------------------------------------------------------
`define SSS_LVL_LOW          2'h0
`define SSS_LVL_OPEN         2'h1
`define SSS_LVL_HIGH         2'h2
`define SSS_SP_FULL          8'hff

// ----------------------------------------------------------------------------
// register map (byte offsets) and fields
// ----------------------------------------------------------------------------
`define SSS_REG_CTRL         4'h0
`define SSS_REG_DELAY        4'h4
`define SSS_REG_RAMP         4'h8
`define SSS_REG_STATUS       4'hc
`define SSS_CTRL_RELOAD      0
`define SSS_CTRL_OVR         1
`define SSS_ST_READY         3
`define SSS_ST_UV            4
`define SSS_ST_DONE          5
`define SSS_ST_OUT           6
`define SSS_ST_SP_LSB        8
`define SSS_RST_TIME         16'h0000

`endif

// ==== sss_pkg.sv ====
package sss_pkg;

    typedef enum logic [2:0] {
        ST_SCAN,
        ST_PINS,
        ST_READY,
        ST_DELAY,
        ST_RAMP,
        ST_ON
    } sss_state_e;

    // delay and ramp in 100 us ticks; uv_high selects the upper threshold
    typedef struct packed {
        logic [15:0] delay;
        logic [15:0] ramp;
        logic        uv_high;
    } sss_cfg_s;

    typedef struct packed {
        logic [1:0] level;
        logic       res_present;
        logic [4:0] res_index;
    } sss_strap_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] delay;
        logic [15:0] ramp;
    } sss_nvm_s;

endpackage

// ==== sss_sequencer.sv ====
// Decided for this implementation: the AHB-Lite slave port and the address map.
`timescale 1ns/10ps
`include "sss_params.svh"

// Operation
// - at power-up scan stored settings, load them, then sample strap pins
// - ignore enable and bus traffic while scanning and sampling pins
// - a reload command over the bus repeats the scan and pin sampling
// - accept bus commands and enable only once in the ready state
// - pre-ramp delay never shorter than 2 ms after enable
// - configured delay above 2 ms is waited out in full
// - after the delay, ramp the output over the configured ramp time
// - delay timer starts when enable is accepted, ends at selected delay
// - ramp is a monotonic non-decreasing series of set-point steps
// - three-level strap selects 2, 5 or 10 ms delay and ramp, low threshold
// - strap resistor index picks delay, ramp and threshold from 32 entries
// - strap is sampled only at power-up or reload and then held
// - software delay and ramp values override the strap values
// - a zero delay starts the ramp after the 2 ms initialisation

module sss_sequencer
    import sss_pkg::*;
#(
    parameter int TICK_CYCLES = `SSS_TICK_CYCLES
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        en,
    input  wire sss_strap_s  strap,
    input  wire sss_nvm_s    nvm,
    output logic             ready,
    output logic             out_en,
    output logic      [7:0]  setpoint,
    output logic             ramp_done,
    output logic             input_undervoltage_threshold
);

    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    sss_state_e  st_q;
    sss_state_e  st_d;
    logic [12:0] div_q;
    logic [15:0] tcnt_q;
    logic [16:0] acc_q;
    logic [7:0]  sp_q;
    sss_cfg_s    strap_cfg_q;
    logic [15:0] sw_delay_q;
    logic [15:0] sw_ramp_q;
    logic        ovr_q;
    logic        dp_wr_q;
    logic [3:0]  dp_addr_q;
    logic [31:0] hrdata_q;
    logic        ready_q;
    logic        out_en_q;
    logic        done_q;
    logic        uv_q;

    // ------------------------------------------------------------------------
    // strap decode
    // ------------------------------------------------------------------------
    function automatic logic [15:0] code_ticks(input logic [1:0] c);
        case (c)
            2'h0:    code_ticks = 16'(`SSS_T2_TICKS);
            2'h1:    code_ticks = 16'(`SSS_T5_TICKS);
            2'h2:    code_ticks = 16'(`SSS_T10_TICKS);
            default: code_ticks = 16'(`SSS_T20_TICKS);
        endcase
    endfunction

    sss_cfg_s strap_dec;

    always_comb begin
        strap_dec = '0;
        if (strap.res_present) begin
            strap_dec.delay   = code_ticks(strap.res_index[3:2]);
            strap_dec.ramp    = code_ticks(strap.res_index[1:0]);
            strap_dec.uv_high = strap.res_index[4];
        end else begin
            case (strap.level)
                `SSS_LVL_OPEN: begin
                    strap_dec.delay = 16'(`SSS_T5_TICKS);
                    strap_dec.ramp  = 16'(`SSS_T5_TICKS);
                end
                `SSS_LVL_HIGH: begin
                    strap_dec.delay = 16'(`SSS_T10_TICKS);
                    strap_dec.ramp  = 16'(`SSS_T10_TICKS);
                end
                default: begin
                    strap_dec.delay = 16'(`SSS_T2_TICKS);
                    strap_dec.ramp  = 16'(`SSS_T2_TICKS);
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // effective timing
    // ------------------------------------------------------------------------
    wire logic [15:0] cfg_delay = ovr_q ? sw_delay_q : strap_cfg_q.delay;
    wire logic [15:0] cfg_ramp  = ovr_q ? sw_ramp_q  : strap_cfg_q.ramp;
    wire logic        delay_short = cfg_delay < 16'(`SSS_MIN_DELAY_TICKS);
    // short or zero delays fall back to the internal initialisation time
    wire logic [15:0] eff_delay = delay_short ? 16'(`SSS_MIN_DELAY_TICKS)
                                              : cfg_delay;
    // a zero ramp would never drain the accumulator, so it acts as one tick
    wire logic [15:0] eff_ramp  = (cfg_ramp == 16'h0000) ? 16'h0001 : cfg_ramp;

    // ------------------------------------------------------------------------
    // tick divider, restarted on every state change so timers start exactly
    // ------------------------------------------------------------------------
    wire logic st_chg   = st_d != st_q;
    wire logic tick     = div_q == 13'(TICK_CYCLES - 1);
    wire logic scan_end = tick && (tcnt_q == 16'(`SSS_SCAN_TICKS - 1));
    wire logic dly_end  = tick && (tcnt_q == eff_delay - 16'h0001);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_q  <= 13'h0000;
            tcnt_q <= 16'h0000;
        end else if (st_chg) begin
            div_q  <= 13'h0000;
            tcnt_q <= 16'h0000;
        end else if (tick) begin
            div_q  <= 13'h0000;
            tcnt_q <= tcnt_q + 16'h0001;
        end else begin
            div_q  <= div_q + 13'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------------------
    // the bus stays closed while stored settings and straps are loading
    wire logic bus_open = (st_q != ST_SCAN) && (st_q != ST_PINS);
    wire logic ap_take  = hsel && hready && htrans[1];
    wire logic wr_en    = dp_wr_q && bus_open;
    wire logic wr_ctrl  = wr_en && (dp_addr_q == `SSS_REG_CTRL);
    wire logic wr_delay = wr_en && (dp_addr_q == `SSS_REG_DELAY);
    wire logic wr_ramp  = wr_en && (dp_addr_q == `SSS_REG_RAMP);
    wire logic reload   = wr_ctrl && hwdata[`SSS_CTRL_RELOAD];

    wire logic [31:0] status_word = {16'h0000, sp_q, 1'b0, out_en_q, done_q,
                                     uv_q, ready_q, st_q};
    wire logic [31:0] ctrl_word   = {30'h00000000, ovr_q, 1'b0};

    logic [31:0] rd_mux;

    always_comb begin
        rd_mux = 32'h00000000;
        if (bus_open) begin
            case (haddr[3:0])
                `SSS_REG_CTRL:   rd_mux = ctrl_word;
                `SSS_REG_DELAY:  rd_mux = {16'h0000, sw_delay_q};
                `SSS_REG_RAMP:   rd_mux = {16'h0000, sw_ramp_q};
                `SSS_REG_STATUS: rd_mux = status_word;
                default:         rd_mux = 32'h00000000;
            endcase
            if (haddr[31:4] != 28'h0000000) begin
                rd_mux = 32'h00000000;
            end
        end
    end

    wire logic addr_ok = haddr[31:4] == 28'h0000000;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_q   <= 1'b0;
            dp_addr_q <= 4'h0;
            hrdata_q  <= 32'h00000000;
        end else begin
            dp_wr_q   <= ap_take && hwrite && addr_ok;
            dp_addr_q <= haddr[3:0];
            if (ap_take && !hwrite) begin
                hrdata_q <= rd_mux;
            end
        end
    end

    // ------------------------------------------------------------------------
    // software and stored settings
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_delay_q <= `SSS_RST_TIME;
            sw_ramp_q  <= `SSS_RST_TIME;
            ovr_q      <= 1'b0;
        end else if (st_q == ST_SCAN) begin
            if (scan_end && nvm.valid) begin
                sw_delay_q <= nvm.delay;
                sw_ramp_q  <= nvm.ramp;
                ovr_q      <= 1'b1;
            end
        end else begin
            if (wr_delay) begin
                sw_delay_q <= hwdata[15:0];
            end
            if (wr_ramp) begin
                sw_ramp_q  <= hwdata[15:0];
            end
            if (wr_ctrl) begin
                ovr_q      <= hwdata[`SSS_CTRL_OVR];
            end
        end
    end

    // strap is held between samples even if the resistor changes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_cfg_q <= '0;
        end else if (st_q == ST_PINS) begin
            strap_cfg_q <= strap_dec;
        end
    end

    // ------------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_SCAN: begin
                if (scan_end) begin
                    st_d = ST_PINS;
                end
            end
            ST_PINS: begin
                st_d = ST_READY;
            end
            ST_READY: begin
                if (en) begin
                    st_d = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!en) begin
                    st_d = ST_READY;
                end else if (dly_end) begin
                    st_d = ST_RAMP;
                end
            end
            ST_RAMP: begin
                if (!en) begin
                    st_d = ST_READY;
                end else if (sp_q == `SSS_SP_FULL) begin
                    st_d = ST_ON;
                end
            end
            ST_ON: begin
                if (!en) begin
                    st_d = ST_READY;
                end
            end
            default: begin
                st_d = ST_SCAN;
            end
        endcase
        if (reload) begin
            st_d = ST_SCAN;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= ST_SCAN;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------------
    // ramp generator
    // ------------------------------------------------------------------------
    // each tick adds a full-scale share; each cycle spends one ramp-time worth
    // as a single step, so the set-point only ever climbs by one
    wire logic        ramping = st_q == ST_RAMP;
    wire logic [16:0] acc_add = acc_q + (tick ? 17'h000ff : 17'h00000);
    wire logic        step    = ramping && (acc_add >= {1'b0, eff_ramp})
                                        && (sp_q != `SSS_SP_FULL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= 17'h00000;
            sp_q  <= 8'h00;
        // cleared on the same edge as out_en, so a reload or an enable drop
        // never leaves a stale set-point behind a low output enable
        end else if ((st_d != ST_RAMP) && (st_d != ST_ON)) begin
            acc_q <= 17'h00000;
            sp_q  <= 8'h00;
        end else if (ramping) begin
            acc_q <= step ? acc_add - {1'b0, eff_ramp} : acc_add;
            if (step) begin
                sp_q <= sp_q + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_q  <= 1'b0;
            out_en_q <= 1'b0;
            done_q   <= 1'b0;
            uv_q     <= 1'b0;
        end else begin
            ready_q  <= (st_d != ST_SCAN) && (st_d != ST_PINS);
            out_en_q <= (st_d == ST_RAMP) || (st_d == ST_ON);
            done_q   <= st_d == ST_ON;
            uv_q     <= strap_cfg_q.uv_high;
        end
    end

    logic hreadyout_q;
    logic hresp_q;

    // zero-wait slave that always answers okay
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end else begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
    end

    assign hrdata                       = hrdata_q;
    assign hreadyout                    = hreadyout_q;
    assign hresp                        = hresp_q;
    assign ready                        = ready_q;
    assign out_en                       = out_en_q;
    assign setpoint                     = sp_q;
    assign ramp_done                    = done_q;
    assign input_undervoltage_threshold = uv_q;

endmodule

// ==== sss_sequencer_sva.sv ====
`timescale 1ns/10ps
`include "sss_params.svh"

module sss_sequencer_sva #(
    parameter int TICK_CYCLES = `SSS_TICK_CYCLES
) (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        en,
    input wire logic        ready,
    input wire logic        out_en,
    input wire logic [7:0]  setpoint,
    input wire logic        ramp_done
);
    localparam int SCAN_CYC = `SSS_SCAN_TICKS * TICK_CYCLES;
    localparam int MIN_CYC  = `SSS_MIN_DELAY_TICKS * TICK_CYCLES;

    logic [15:0] idle_q;
    logic [15:0] wait_q;
    logic        rd_q;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // wait_q restarts whenever enable drops, so an abandoned delay never counts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_q <= 16'h0000;
            wait_q <= 16'h0000;
            rd_q   <= 1'b0;
        end else begin
            idle_q <= ready ? 16'h0000 : idle_q + 16'h0001;
            wait_q <= (en && ready && !out_en) ? wait_q + 16'h0001 : 16'h0000;
            rd_q   <= hsel && hready && htrans[1] && !hwrite;
        end
    end

    chk_zero_wait: assert property (hreadyout) else $error("wait state inserted");
    chk_resp_okay: assert property (!hresp) else $error("error response");
    chk_scan_quiet: assert property (!ready |-> !out_en && setpoint == 8'h00)
        else $error("output active before ready");
    chk_scan_length: assert property ($rose(ready) |-> idle_q >= SCAN_CYC - 1)
        else $error("scan ended early");
    chk_min_delay: assert property ($rose(out_en) |-> wait_q >= MIN_CYC)
        else $error("ramp started before minimum delay");
    chk_en_drop: assert property (!en |-> ##2 !out_en)
        else $error("output stayed on after enable dropped");
    chk_ramp_mono: assert property (out_en && $past(out_en) |-> setpoint >= $past(setpoint))
        else $error("set-point stepped down");
    chk_ramp_start: assert property ($rose(out_en) |-> setpoint <= 8'h01)
        else $error("ramp did not start from zero");
    chk_done_full: assert property (ramp_done |-> out_en && setpoint == 8'hff)
        else $error("done without full set-point");
    chk_scan_read: assert property (rd_q && !ready && !$past(ready) |-> hrdata == 32'h0)
        else $error("read answered during scan");
endmodule

bind sss_sequencer sss_sequencer_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .en(en),
    .ready(ready), .out_en(out_en), .setpoint(setpoint), .ramp_done(ramp_done)
);

// ==== sss_host_model.sv ====
`timescale 1ns/10ps

module sss_host_model (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata,
    output logic             en
);
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize  = 3'h0;
        hwdata = 32'h0;
        en     = 1'b0;
    end

    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hready !== 1'b1 && n < 100);
        if (hready !== 1'b1) begin
            tb_startup_soft_start_sequencer.fail_count++;
            tb_startup_soft_start_sequencer.complete_run();
        end
    endtask

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize  <= 3'h2;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hsize  <= 3'h0;
        // released address and data are scrambled so a stale value cannot match
        haddr  <= ~a;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        hwdata <= ~d;
    endtask

    task automatic drive_en(input logic v);
        @(posedge hclk);
        en <= v; // no sync clock here, so it is trivially stable before enable
    endtask
endmodule

// ==== tb_startup_soft_start_sequencer.sv ====
`timescale 1ns/10ps

module tb_startup_soft_start_sequencer
    import sss_pkg::*;
;
    localparam int TC = 50;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        en;
    sss_strap_s  strap;
    sss_nvm_s    nvm;
    logic        ready;
    logic        out_en;
    logic [7:0]  setpoint;
    logic        ramp_done;
    logic        uv_thr;
    int          fail_count;
    int          total_checks;
    int          n;
    int          dl_tab[3] = '{0, 5, 30};
    // last entry reaches the 20 ms delay and ramp codes of the resistor decode
    logic [7:0]  st_tab[5] = '{8'h00, 8'h40, 8'h80, 8'h36, 8'h2f};
    int          sd_tab[5] = '{20, 50, 100, 50, 200};
    int          sr_tab[5] = '{20, 50, 100, 100, 200};

    sss_sequencer #(.TICK_CYCLES(TC)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .en(en), .strap(strap), .nvm(nvm), .ready(ready),
        .out_en(out_en), .setpoint(setpoint), .ramp_done(ramp_done),
        .input_undervoltage_threshold(uv_thr)
    );

    sss_host_model u_host (
        .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .en(en)
    );

    initial hclk = 1'b0;
    always #10 hclk = ~hclk;

    // ------------------------------------------------------------
    // compare, bus and sequence helpers
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            fail_count++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    task automatic chk_rng(input string nm, input int lo, input int hi, input int g);
        total_checks++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("BAD %s exp %0d..%0d got %0d", nm, lo, hi, g);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        u_host.xfer(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        u_host.xfer(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    // bounded wait: a hang is counted and ends the run
    task automatic wait_hi(ref logic s, input int lim, output int cnt);
        cnt = 0;
        while (s !== 1'b1) begin
            @(negedge hclk);
            cnt++;
            if (cnt > lim) begin
                chk("timeout", 32'h1, 32'h0);
                complete_run();
            end
        end
    endtask

    // ramp window is one tick wide either way: steps come in bursts that start on tick boundaries
    task automatic run_en(input int dl, input int rp, input logic thr);
        int c;
        u_host.drive_en(1'b1);
        wait_hi(out_en, 20000, c);
        chk_rng("delay", dl * TC, dl * TC + 5, c);
        wait_hi(ramp_done, 20000, c);
        chk_rng("ramp", (rp - 1) * TC, (rp + 1) * TC + 4, c);
        chk("threshold", {31'h0, thr}, {31'h0, uv_thr});
        u_host.drive_en(1'b0);
        repeat (3) @(negedge hclk);
        chk("out_en off", 32'h0, {31'h0, out_en});
    endtask

    task automatic complete_run();
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        fail_count = 0;
        total_checks = 0;
        hresetn = 1'b0;
        strap = '0;
        nvm = '0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        u_host.drive_en(1'b1);
        wr(32'h4, 32'h33);
        rd_chk("scan status", 32'hc, 32'h0);
        repeat (50) @(posedge hclk);
        chk("scan out_en", 32'h0, {31'h0, out_en});
        u_host.drive_en(1'b0);
        wait_hi(ready, 4000, n);
        rd_chk("dropped write", 32'h4, 32'h0);
        rd_chk("unmapped", 32'h20, 32'h0);
        rd_chk("status", 32'hc, 32'ha);
        wr(32'h8, 32'h6); // ramp kept above 500 us
        wr(32'h0, 32'h2);
        foreach (dl_tab[i]) begin
            wr(32'h4, dl_tab[i]);
            rd_chk("delay reg", 32'h4, dl_tab[i]);
            run_en(dl_tab[i] > 20 ? dl_tab[i] : 20, 6, 1'b0);
        end
        u_host.drive_en(1'b1);
        repeat (300) @(posedge hclk);
        u_host.drive_en(1'b0);
        repeat (3) @(negedge hclk);
        chk("abort", 32'h0, {31'h0, out_en});
        run_en(30, 6, 1'b0);
        foreach (st_tab[i]) begin
            @(posedge hclk);
            strap <= st_tab[i];
            wr(32'h0, 32'h1);
            repeat (2) @(negedge hclk);
            chk("reload", 32'h0, {31'h0, ready});
            wait_hi(ready, 4000, n);
            @(posedge hclk);
            strap <= 8'hbf;
            run_en(sd_tab[i], sr_tab[i], i == 3);
        end
        @(posedge hclk);
        strap <= 8'h00;
        nvm <= {1'b1, 16'h0028, 16'h000a};
        wr(32'h0, 32'h1);
        repeat (2) @(negedge hclk);
        wait_hi(ready, 4000, n);
        rd_chk("stored ctrl", 32'h0, 32'h2);
        run_en(40, 10, 1'b0);
        complete_run();
    end
endmodule
